// ===== acle_consts.vh
// constants for the add-with-carry and logic execute datapath
`ifndef ACLE_CONSTS_VH
`define ACLE_CONSTS_VH

// =====================================================================
// opcode upper-byte patterns
`define ACLE_OP_ADDC_HI   7'h08
`define ACLE_OP_ANDF_HI   7'h05
`define ACLE_OP_ANDL      8'hb5
`define ACLE_DEST_BIT     8

// =====================================================================
// register offsets (byte addresses)
`define ACLE_OFF_INSN     8'h00
`define ACLE_OFF_WORKING_REGISTER     8'h04
`define ACLE_OFF_STATUS   8'h08
`define ACLE_OFF_FILE     8'h0c
`define ACLE_OFF_CTRL     8'h10

// =====================================================================
// status field positions
`define ACLE_ST_CARRY     0
`define ACLE_ST_DC        1
`define ACLE_ST_ZERO      2
`define ACLE_ST_OV        3
`define ACLE_ST_BUSY      4
`define ACLE_ST_ILLEGAL   5

// =====================================================================
// reset values
`define ACLE_WORKING_REGISTER_RST     8'h00
`define ACLE_FLAGS_RST    4'h0
`define ACLE_FILE_RST     8'h00

// =====================================================================
// phase timing
`define ACLE_PHASES       4

`endif

// ===== acle_alu.v
// arithmetic and logic unit for the execute datapath
`timescale 1ns/1ns

module acle_alu
(
    // operands
    input  wire [7:0] a_in,
    input  wire [7:0] b_in,
    input  wire       carry_in,
    input  wire       sel_and,
    // results
    output reg  [7:0] result,
    output reg        carry_out,
    output reg        dc_out,
    output reg        ov_out,
    output wire       zero_out
);

    reg [4:0] low_sum;
    reg [8:0] full_sum;

    always @*
    begin
        low_sum   = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, carry_in};
        full_sum  = {1'b0, a_in} + {1'b0, b_in} + {8'h00, carry_in};
        carry_out = full_sum[8];
        dc_out    = low_sum[4];
        // signed overflow: same-sign inputs, different-sign sum
        ov_out    = (a_in[7] == b_in[7]) && (full_sum[7] != a_in[7]);
        if (sel_and)
            result = a_in & b_in;
        else
            result = full_sum[7:0];
    end

    assign zero_out = (result == 8'h00);

endmodule // acle_alu

// ===== acle_exec.v
// execute datapath for add-with-carry and the two and instructions
// =====================================================================
// Notes on behaviour
// - add-with-carry 0001 000d ffff ffff: working+file+carry; sets ov, c, dc, z.
// - add-with-carry destination bit: 0 to working register, 1 to file.
// - and-literal 1011 0101 kkkk kkkk: working and literal to working; zero only.
// - and-with-file 0000 101d ffff ffff: working and file; zero flag only.
// - and-with-file destination bit: 0 to working register, 1 to file.
// =====================================================================
`timescale 1ns/1ns
`include "acle_consts.vh"

module acle_exec
(
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // =================================================================
    // phase states
    localparam [4:0] PH_IDLE = 5'b00001;
    localparam [4:0] PH_DEC  = 5'b00010;
    localparam [4:0] PH_RD   = 5'b00100;
    localparam [4:0] PH_PROC = 5'b01000;
    localparam [4:0] PH_WR   = 5'b10000;

    reg [4:0]  phase_reg;
    reg [15:0] insn_reg;
    reg [7:0]  working_register_reg;
    reg [7:0]  file_reg;
    reg [7:0]  operand_reg;
    reg [7:0]  result_reg;
    reg        carry_flag_reg;
    reg        digit_carry_flag_reg;
    reg        zero_flag_reg;
    reg        overflow_flag_reg;
    reg        illegal_reg;
    reg        c_res_reg;
    reg        dc_res_reg;
    reg        ov_res_reg;
    reg        z_res_reg;
    reg        is_addc_reg;
    reg        is_andl_reg;
    reg        is_andf_reg;

    // =================================================================
    // axi4-lite slave: address and data captured independently
    reg        aw_hold_reg;
    reg [7:0]  aw_addr_reg;
    reg        w_hold_reg;
    reg [31:0] w_data_reg;
    reg [3:0]  w_strb_reg;

    assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_hold_reg & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire wr_fire = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
    wire busy    = (phase_reg != PH_IDLE);

    wire wr_insn = wr_fire && aw_addr_reg == `ACLE_OFF_INSN && w_strb_reg[1:0] == 2'b11;
    wire wr_ok   = aw_addr_reg == `ACLE_OFF_INSN || aw_addr_reg == `ACLE_OFF_WORKING_REGISTER ||
                   aw_addr_reg == `ACLE_OFF_STATUS || aw_addr_reg == `ACLE_OFF_FILE ||
                   aw_addr_reg == `ACLE_OFF_CTRL;
    wire sw_wr   = wr_fire & ~busy;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_reg  <= 1'b0;
            aw_addr_reg  <= 8'h00;
            w_hold_reg   <= 1'b0;
            w_data_reg   <= 32'h0000_0000;
            w_strb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // slverr on unmapped address or write while executing
                s_axi_bresp  <= (wr_ok && !busy) ? 2'b00 : 2'b10;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // =================================================================
    // read channel
    reg [31:0] rd_mux;
    reg        rd_ok;

    always @*
    begin
        rd_ok  = 1'b1;
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            `ACLE_OFF_INSN:   rd_mux = {16'h0000, insn_reg};
            `ACLE_OFF_WORKING_REGISTER:   rd_mux = {24'h000000, working_register_reg};
            `ACLE_OFF_STATUS: rd_mux = {26'h0, illegal_reg, busy, overflow_flag_reg,
                                        zero_flag_reg, digit_carry_flag_reg,
                                        carry_flag_reg};
            `ACLE_OFF_FILE:   rd_mux = {24'h000000, file_reg};
            `ACLE_OFF_CTRL:   rd_mux = 32'h0000_0000;
            default:          rd_ok  = 1'b0;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // =================================================================
    // alu
    wire [7:0] alu_res;
    wire       alu_c;
    wire       alu_dc;
    wire       alu_ov;
    wire       alu_z;

    acle_alu u_alu
    (
        .a_in      (working_register_reg),
        .b_in      (operand_reg),
        .carry_in  (is_addc_reg & carry_flag_reg),
        .sel_and   (~is_addc_reg),
        .result    (alu_res),
        .carry_out (alu_c),
        .dc_out    (alu_dc),
        .ov_out    (alu_ov),
        .zero_out  (alu_z)
    );

    wire dest_file = insn_reg[`ACLE_DEST_BIT];

    // =================================================================
    // four-phase instruction cycle and architectural state
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            phase_reg            <= PH_IDLE;
            insn_reg             <= 16'h0000;
            working_register_reg <= `ACLE_WORKING_REGISTER_RST;
            file_reg             <= `ACLE_FILE_RST;
            operand_reg          <= 8'h00;
            result_reg           <= 8'h00;
            {overflow_flag_reg, zero_flag_reg, digit_carry_flag_reg, carry_flag_reg}
                                 <= `ACLE_FLAGS_RST;
            {c_res_reg, dc_res_reg, ov_res_reg, z_res_reg} <= 4'h0;
            {is_addc_reg, is_andl_reg, is_andf_reg}         <= 3'b000;
            illegal_reg          <= 1'b0;
        end
        else
        begin
            case (phase_reg)
                PH_IDLE:
                begin
                    if (sw_wr && wr_insn)
                    begin
                        insn_reg  <= w_data_reg[15:0];
                        phase_reg <= PH_DEC;
                    end
                    else if (sw_wr && aw_addr_reg == `ACLE_OFF_WORKING_REGISTER && w_strb_reg[0])
                        working_register_reg <= w_data_reg[7:0];
                    else if (sw_wr && aw_addr_reg == `ACLE_OFF_FILE && w_strb_reg[0])
                        file_reg <= w_data_reg[7:0];
                    else if (sw_wr && aw_addr_reg == `ACLE_OFF_STATUS && w_strb_reg[0])
                        {overflow_flag_reg, zero_flag_reg, digit_carry_flag_reg,
                         carry_flag_reg} <= w_data_reg[3:0];
                end
                // decode
                PH_DEC:
                begin
                    is_addc_reg <= insn_reg[15:9] == `ACLE_OP_ADDC_HI;
                    is_andl_reg <= insn_reg[15:8] == `ACLE_OP_ANDL;
                    is_andf_reg <= insn_reg[15:9] == `ACLE_OP_ANDF_HI;
                    phase_reg   <= PH_RD;
                end
                // read operand: literal or file register
                PH_RD:
                begin
                    illegal_reg <= ~(is_addc_reg | is_andl_reg | is_andf_reg);
                    operand_reg <= is_andl_reg ? insn_reg[7:0] : file_reg;
                    phase_reg   <= PH_PROC;
                end
                // process data
                PH_PROC:
                begin
                    result_reg <= alu_res;
                    c_res_reg  <= alu_c;
                    dc_res_reg <= alu_dc;
                    ov_res_reg <= alu_ov;
                    z_res_reg  <= alu_z;
                    phase_reg  <= PH_WR;
                end
                // write destination and flags
                PH_WR:
                begin
                    phase_reg <= PH_IDLE;
                    if (is_addc_reg)
                    begin
                        carry_flag_reg       <= c_res_reg;
                        digit_carry_flag_reg <= dc_res_reg;
                        overflow_flag_reg    <= ov_res_reg;
                        zero_flag_reg        <= z_res_reg;
                    end
                    else if (is_andl_reg || is_andf_reg)
                        zero_flag_reg <= z_res_reg;
                    if ((is_addc_reg || is_andf_reg) && dest_file)
                        file_reg <= result_reg;
                    else if (is_addc_reg || is_andf_reg || is_andl_reg)
                        working_register_reg <= result_reg;
                end
                default:
                    phase_reg <= PH_IDLE;
            endcase
        end
    end

endmodule // acle_exec

// ===== acle_exec_assertions.sv
// concurrent checks on the execute datapath register bus
`timescale 1ns/1ns

module acle_exec_assertions
(
    // clock and reset
    input wire        aclk,
    input wire        aresetn,
    // write channels
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0]  s_axi_wstrb,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    // read channels
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // =====================================================================
    // steps of an instruction launch
    sequence insn_ok;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 8'h00
        && s_axi_wstrb[1:0] == 2'b11 ##[1:2] s_axi_bvalid && s_axi_bresp == 2'b00;
    endsequence
    sequence status_probe;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h08;
    endsequence

    // =====================================================================
    // bus and execution checks
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed before bready");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed before rready");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read not answered in time");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write not answered in time");
    chk_ready_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_ar_gate: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready not the inverse of rvalid");
    chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
        |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0))
        else $error("unmapped read not refused");
    chk_busy_shown: assert property (insn_ok ##[1:2] status_probe |-> ##[1:2] (s_axi_rvalid && s_axi_rdata[4]))
        else $error("busy not shown right after launch");
endmodule // acle_exec_assertions

bind acle_exec acle_exec_assertions u_chk (.*);

// ===== acle_exec_test.sv
// self-checking bench for the execute datapath
`timescale 1ns/1ns
`include "acle_consts.vh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module acle_exec_test;
    logic aclk = 0, aresetn = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] d;
    int failures = 0, total_checks = 0, cycles = 0;
    // case table: insn, working, file, flags preset, expected working, file, status
    logic [15:0] ti[8] = '{16'h1022, 16'h1122, 16'h1022, 16'hb55f, 16'hb500, 16'h0b33, 16'h0a33, 16'hffff};
    logic [7:0] tw[8] = '{8'h17, 8'h80, 8'h0f, 8'ha3, 8'hff, 8'h17, 8'h0f, 8'h12};
    logic [7:0] tf[8] = '{8'hc2, 8'h80, 8'h70, 8'h55, 8'h55, 8'hc2, 8'hf0, 8'h34};
    logic [3:0] tl[8] = '{4'h1, 4'h0, 4'h1, 4'hb, 4'h0, 4'hf, 4'hb, 4'h5};
    logic [7:0] ew[8] = '{8'hda, 8'h80, 8'h80, 8'h03, 8'h00, 8'h17, 8'h00, 8'h12};
    logic [7:0] ef[8] = '{8'hc2, 8'h00, 8'h70, 8'h55, 8'h55, 8'h02, 8'hf0, 8'h34};
    logic [5:0] es[8] = '{6'h00, 6'h0d, 6'h0a, 6'h0b, 6'h04, 6'h0b, 6'h0f, 6'h25};

    acle_exec DUT (.*);

    initial forever #2 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin failures++; conclude(); end
    end

    // =====================================================================
    // bus tasks
    task automatic wr(input [7:0] a, input [31:0] v);
        int n = 0;
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        do begin
            @(posedge aclk);
            if (n == 0) s_axi_bready <= 1;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            n++;
        end while (!(s_axi_bvalid && s_axi_bready));
        r = s_axi_bresp; s_axi_bready <= 0;
    endtask
    task automatic rd(input [7:0] a);
        int n = 0;
        s_axi_araddr <= a; s_axi_arvalid <= 1;
        do begin
            @(posedge aclk);
            if (n == 1) s_axi_rready <= 1;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
            n++;
        end while (!(s_axi_rvalid && s_axi_rready));
        d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
    endtask
    task automatic idle;
        int n = 0;
        do begin rd(`ACLE_OFF_STATUS); n++; end while (d[4] !== 1'b0 && n < 8);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // =====================================================================
    // main sequence
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(`ACLE_OFF_WORKING_REGISTER); `CHK("working_register rst", 8'h00, d[7:0])
        rd(`ACLE_OFF_FILE); `CHK("file rst", 8'h00, d[7:0])
        rd(`ACLE_OFF_STATUS); `CHK("status rst", 6'h00, d[5:0])
        rd(8'h14); `CHK("unmapped rd", 34'h2_0000_0000, {r, d})
        wr(8'h20, 32'h1); `CHK("unmapped wr", 2'b10, r)
        for (int i = 0; i < 8; i++) begin
            wr(`ACLE_OFF_WORKING_REGISTER, tw[i]); wr(`ACLE_OFF_FILE, tf[i]); wr(`ACLE_OFF_STATUS, tl[i]);
            wr(`ACLE_OFF_INSN, ti[i]); `CHK("insn resp", 2'b00, r)
            rd(`ACLE_OFF_STATUS); `CHK("busy", 1'b1, d[4])
            idle();
            rd(`ACLE_OFF_WORKING_REGISTER); `CHK("working_register", ew[i], d[7:0])
            rd(`ACLE_OFF_FILE); `CHK("file", ef[i], d[7:0])
            rd(`ACLE_OFF_STATUS); `CHK("status", es[i], d[5:0])
        end
        // write during execution refused, result still lands
        wr(`ACLE_OFF_WORKING_REGISTER, 32'h3c); wr(`ACLE_OFF_INSN, 32'hb50f);
        wr(`ACLE_OFF_WORKING_REGISTER, 32'hee); `CHK("busy wr", 2'b10, r)
        idle();
        rd(`ACLE_OFF_WORKING_REGISTER); `CHK("working_register after busy", 8'h0c, d[7:0])
        rd(`ACLE_OFF_CTRL); `CHK("ctrl", 34'h0, {r, d})
        conclude();
    end
endmodule // acle_exec_test
